// ---- logic/fpec_ctrl.sv ----
// program/erase controller with internal array model
`timescale 1ns/1ps
`default_nettype none
`include "fpec_map.svh"

module fpec_ctrl #(
  parameter int ADDR_W = `FPEC_ADDR_W,
  parameter int PROG_CYCLES = `FPEC_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FPEC_ERASE_CYCLES
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // host command port
  input  wire logic              CMD_VALID,
  input  wire fpec_pkg::fpec_req_t CMD,
  input  wire logic              CHIP_SEL,
  // answers
  output logic [15:0]            READ_DATA,
  output logic                   READ_VALID,
  output fpec_pkg::fpec_stat_t   STATUS,
  output logic                   BUSY
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_RECOVER, ST_STANDBY, ST_PROGRAM, ST_ERASE, ST_PROG_SUSP, ST_ERASE_SUSP, ST_LOW_POWER
  } fpec_state_t;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HALF = 1 << `FPEC_HALF_PAGE_W;

  logic [15:0] main_mem [DEPTH];
  logic [15:0] map_mem  [DEPTH];
  logic [15:0] pbuf [HALF];

  fpec_state_t state, next_state;
  logic        map_window, next_map_window;
  logic        op_map, next_op_map;      // space where routine began
  logic        op_buf, next_op_buf;
  logic [ADDR_W-1:0] op_addr, next_op_addr;
  logic [15:0] op_data, next_op_data;
  logic [15:0] count, next_count;
  logic [15:0] rdata, next_rdata;
  logic        rvalid, next_rvalid;
  logic        done, next_done;
  logic        cs_s1, cs_s2;
  logic        ret_susp, next_ret_susp;    // program started from erase suspend
  logic        erase_map, next_erase_map;  // space of the erase in flight
  logic [ADDR_W-1:0] erase_addr, next_erase_addr;
  logic [15:0] erase_left, next_erase_left; // erase cycles still owed after suspend

  wire fpec_pkg::fpec_cmd_t c = CMD_VALID ? CMD.cmd : fpec_pkg::CMD_NONE;
  wire [ADDR_W-1:0] a = CMD.addr[ADDR_W-1:0];
  wire same_sector = a[ADDR_W-1:`FPEC_SECTOR_W] == erase_addr[ADDR_W-1:`FPEC_SECTOR_W];
  wire same_line = a[ADDR_W-1:`FPEC_LINE_W] == op_addr[ADDR_W-1:`FPEC_LINE_W];

  // chip select synchronised but unused; it is not reported and never gates a routine
  always_ff @(posedge CLK) begin
    cs_s1 <= CHIP_SEL;
    cs_s2 <= cs_s1;
  end

  // ==========================================================
  // command filter and sequencer
  always_comb begin
    next_state = state;
    next_map_window = map_window;
    next_op_map = op_map;
    next_op_buf = op_buf;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_count = count;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_done = done;
    next_ret_susp = ret_susp;
    next_erase_map = erase_map;
    next_erase_addr = erase_addr;
    next_erase_left = erase_left;
    unique case (state)
      ST_RECOVER: begin
        next_count = count - 16'h0001;
        if (count == 16'h0001) next_state = ST_STANDBY;
      end
      ST_STANDBY, ST_ERASE_SUSP: begin
        unique case (c)
          fpec_pkg::CMD_READ: begin
            next_rvalid = 1'b1;
            next_rdata = map_window ? map_mem[a] : main_mem[a];
          end
          fpec_pkg::CMD_STATUS: next_rvalid = 1'b1;
          fpec_pkg::CMD_WORD_PROG, fpec_pkg::CMD_BUF_PROG: begin
            if (state == ST_STANDBY || !same_sector) begin
              next_state = ST_PROGRAM;
              next_op_buf = (c == fpec_pkg::CMD_BUF_PROG);
              next_op_map = map_window;
              next_op_data = CMD.data;
              next_count = 16'(PROG_CYCLES);
              next_done = 1'b0;
              next_op_addr = a;
              next_ret_susp = (state == ST_ERASE_SUSP);
            end
          end
          fpec_pkg::CMD_ERASE: begin
            if (state == ST_STANDBY) begin
              next_state = ST_ERASE;
              next_erase_map = map_window;
              next_erase_addr = a;
              next_count = 16'(ERASE_CYCLES);
              next_done = 1'b0;
            end
          end
          fpec_pkg::CMD_ERASE_RES: begin
            if (state == ST_ERASE_SUSP) begin
              next_state = ST_ERASE;
              next_count = erase_left;                             // counter was reused by the program
            end
          end
          fpec_pkg::CMD_MAP_ENTER: if (state == ST_STANDBY) next_map_window = 1'b1;
          fpec_pkg::CMD_MAP_EXIT: next_map_window = 1'b0;
          fpec_pkg::CMD_LOW_POWER: begin
            if (state == ST_ERASE_SUSP || !map_window) next_state = ST_LOW_POWER;
          end
          default: ;
        endcase
      end
      ST_PROGRAM: begin
        next_count = count - 16'h0001;
        if (c == fpec_pkg::CMD_STATUS) next_rvalid = 1'b1;
        if (count == 16'h0001) begin
          next_done = 1'b1;
          next_state = ret_susp ? ST_ERASE_SUSP : ST_STANDBY;
        end else if (c == fpec_pkg::CMD_PROG_SUSP) next_state = ST_PROG_SUSP;
      end
      ST_ERASE: begin
        next_count = count - 16'h0001;
        if (c == fpec_pkg::CMD_STATUS) next_rvalid = 1'b1;
        if (count == 16'h0001) begin
          next_done = 1'b1;
          next_state = ST_STANDBY;
        end else if (c == fpec_pkg::CMD_ERASE_SUSP) begin
          next_state = ST_ERASE_SUSP;
          next_erase_left = count - 16'h0001;
        end
      end
      ST_PROG_SUSP: begin
        if (c == fpec_pkg::CMD_READ && !same_line) begin
          next_rvalid = 1'b1;
          next_rdata = map_window ? map_mem[a] : main_mem[a];
        end
        if (c == fpec_pkg::CMD_STATUS) next_rvalid = 1'b1;
        if (c == fpec_pkg::CMD_PROG_RES) next_state = ST_PROGRAM;
        if (c == fpec_pkg::CMD_LOW_POWER) next_state = ST_LOW_POWER;
      end
      ST_LOW_POWER: begin
        if (c == fpec_pkg::CMD_WAKE) next_state = ST_STANDBY;
      end
      default: next_state = ST_STANDBY;
    endcase
    if (RESET) begin
      next_state = ST_RECOVER;
      next_map_window = 1'b0;
      next_count = 16'(`FPEC_RECOVER_CYCLES);
      next_done = 1'b0;
      next_rvalid = 1'b0;
      next_ret_susp = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    state <= next_state;
    map_window <= next_map_window;
    op_map <= next_op_map;
    op_buf <= next_op_buf;
    op_addr <= next_op_addr;
    op_data <= next_op_data;
    count <= next_count;
    rdata <= next_rdata;
    rvalid <= next_rvalid;
    done <= next_done;
    ret_susp <= next_ret_susp;
    erase_map <= next_erase_map;
    erase_addr <= next_erase_addr;
    erase_left <= next_erase_left;
  end

  // ==========================================================
  // array update: program ANDs, erase fills with ones
  // a suspend in the last cycle loses to completion, so no zero-length resume exists
  wire fin_prog = state == ST_PROGRAM && count == 16'h0001 && !RESET;
  wire fin_erase = state == ST_ERASE && count == 16'h0001 && !RESET;
  wire [ADDR_W-1:0] hp_base = {op_addr[ADDR_W-1:`FPEC_HALF_PAGE_W], `FPEC_HALF_PAGE_W'(0)};

  // half-page buffer: only the addressed word carries data, rest stays erased
  generate
    for (genvar i = 0; i < HALF; i++) begin : g_hp
      assign pbuf[i] = (op_addr[`FPEC_HALF_PAGE_W-1:0] == `FPEC_HALF_PAGE_W'(i)) ? op_data : `FPEC_ERASED_WORD;
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (fin_prog) begin
      for (int i = 0; i < HALF; i++) begin
        if (op_map) map_mem[hp_base + ADDR_W'(i)] <= map_mem[hp_base + ADDR_W'(i)] & pbuf[i];
        else main_mem[hp_base + ADDR_W'(i)] <= main_mem[hp_base + ADDR_W'(i)] & pbuf[i];
      end
    end
    if (fin_erase) begin
      for (int i = 0; i < (1 << `FPEC_SECTOR_W); i++) begin
        if (erase_map) map_mem[{erase_addr[ADDR_W-1:`FPEC_SECTOR_W], `FPEC_SECTOR_W'(i)}] <= `FPEC_ERASED_WORD;
        else main_mem[{erase_addr[ADDR_W-1:`FPEC_SECTOR_W], `FPEC_SECTOR_W'(i)}] <= `FPEC_ERASED_WORD;
      end
    end
  end

  // ==========================================================
  // outputs
  assign BUSY = state == ST_PROGRAM || state == ST_ERASE;
  assign READ_DATA = rdata;
  assign READ_VALID = rvalid;
  assign STATUS = '{busy: BUSY, prog_busy: state == ST_PROGRAM, erase_busy: state == ST_ERASE,
                    prog_susp: state == ST_PROG_SUSP, erase_susp: state == ST_ERASE_SUSP,
                    map_window: map_window, low_power: state == ST_LOW_POWER, done: done};

  // ==========================================================
  // checks
  chk_prog_filter: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_PROGRAM && CMD_VALID && CMD.cmd == fpec_pkg::CMD_ERASE |=> state != ST_ERASE)
    else $error("erase accepted during program");
  chk_erase_filter: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_ERASE && CMD_VALID && CMD.cmd == fpec_pkg::CMD_WORD_PROG |=> state != ST_PROGRAM)
    else $error("program accepted during erase");
  chk_busy_flag: assert property (@(posedge CLK) BUSY == (state == ST_PROGRAM || state == ST_ERASE))
    else $error("busy mismatch");
  chk_low_power: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_STANDBY && map_window |=> state != ST_LOW_POWER)
    else $error("low power entered from overlay");
  chk_reset_abort: assert property (@(posedge CLK) RESET |=> state == ST_RECOVER && !BUSY)
    else $error("reset did not abort");
  chk_map_exit: assert property (@(posedge CLK) disable iff (RESET)
    CMD_VALID && CMD.cmd == fpec_pkg::CMD_MAP_EXIT && state == ST_STANDBY |=> !map_window)
    else $error("overlay not exited");
  chk_prog_susp: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_PROG_SUSP && CMD_VALID && CMD.cmd == fpec_pkg::CMD_ERASE |=> state == ST_PROG_SUSP)
    else $error("erase accepted in program suspend");
  chk_erase_susp: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_ERASE_SUSP && CMD_VALID && CMD.cmd == fpec_pkg::CMD_ERASE |=> state == ST_ERASE_SUSP)
    else $error("erase accepted in erase suspend");
  chk_prog_time: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_PROGRAM && count != 16'h0001 && !(CMD_VALID && CMD.cmd == fpec_pkg::CMD_PROG_SUSP)
    |=> state == ST_PROGRAM)
    else $error("program stopped early");
endmodule
`default_nettype wire

// ---- logic/fpec_map.svh ----
// constants for the flash program/erase controller
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
`define FPEC_WORD_W        16
`define FPEC_ADDR_W        16
`define FPEC_HALF_PAGE_W   3
`define FPEC_LINE_W        8
`define FPEC_SECTOR_W      11
`define FPEC_ERASED_WORD   16'hffff
`define FPEC_PROG_CYCLES   8
`define FPEC_ERASE_CYCLES  4
`define FPEC_RESET_NS      40
`define FPEC_CLK_NS        8
`define FPEC_RECOVER_CYCLES ((`FPEC_RESET_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS)
`endif

// ---- logic/fpec_pkg.sv ----
// types shared by the flash program/erase controller
package fpec_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_READ, CMD_STATUS, CMD_WORD_PROG, CMD_BUF_LOAD, CMD_BUF_PROG,
    CMD_ERASE, CMD_PROG_SUSP, CMD_ERASE_SUSP, CMD_PROG_RES, CMD_ERASE_RES,
    CMD_MAP_ENTER, CMD_MAP_EXIT, CMD_LOW_POWER, CMD_WAKE
  } fpec_cmd_t;

  typedef struct packed {
    fpec_cmd_t   cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } fpec_req_t;

  typedef struct packed {
    logic busy;
    logic prog_busy;
    logic erase_busy;
    logic prog_susp;
    logic erase_susp;
    logic map_window;
    logic low_power;
    logic done;
  } fpec_stat_t;
endpackage

// ---- tb/fpec_host.sv ----
// host-side command issuer for the flash controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host model
module fpec_host (
  // clock
  input  wire logic           CLK,
  // command port towards the controller
  output logic                CMD_VALID,
  output fpec_pkg::fpec_req_t CMD
);
  initial begin
    CMD_VALID = 1'b0;
    CMD = '0;
  end
  // one command per call; after use cmd returns to CMD_NONE and addr/data are inverted so stale values never look fresh
  task automatic send(input fpec_pkg::fpec_cmd_t c, input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1;
    CMD_VALID = 1'b1;
    CMD = '{cmd: c, addr: a, data: d};
    @(posedge CLK);
    #1;
    CMD_VALID = 1'b0;
    CMD = '{cmd: fpec_pkg::CMD_NONE, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire

// ---- tb/test_flash_program_erase_controller.sv ----
// self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench top
module test_flash_program_erase_controller;
  logic                 CLK = 1'b0;
  logic                 RESET = 1'b1;
  logic                 CHIP_SEL = 1'b1;
  logic                 CMD_VALID;
  fpec_pkg::fpec_req_t  CMD;
  logic [15:0]          READ_DATA;
  logic                 READ_VALID;
  fpec_pkg::fpec_stat_t STATUS;
  logic                 BUSY;
  int                   bad_count = 0;
  int                   cmp_count = 0;
  fpec_ctrl #(.ADDR_W(16), .PROG_CYCLES(8), .ERASE_CYCLES(4)) u_dut (
    .CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD(CMD), .CHIP_SEL(CHIP_SEL),
    .READ_DATA(READ_DATA), .READ_VALID(READ_VALID), .STATUS(STATUS), .BUSY(BUSY));
  fpec_host u_host (.CLK(CLK), .CMD_VALID(CMD_VALID), .CMD(CMD));
  // 125 MHz clock
  always #4 CLK = ~CLK;
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait for the routine to end
  task automatic wait_idle;
    for (int i = 0; i < 40 && BUSY !== 1'b0; i++) begin
      @(posedge CLK);
      #1;
    end
    check({15'h0, BUSY}, 16'h0);
  endtask
  // read answer is registered on the taking edge and checked just after it
  task automatic read_word(input logic [15:0] a, input logic [15:0] exp);
    u_host.send(fpec_pkg::CMD_READ, a, 16'h0);
    check({15'h0, READ_VALID}, 16'h1);
    check(READ_DATA, exp);
  endtask
  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    u_host.send(fpec_pkg::CMD_WORD_PROG, a, d);
    check({15'h0, BUSY}, 16'h1);
    wait_idle();
  endtask
  // ==========================================
  // scenarios
  task automatic t_program;
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0000, 16'h0);
    wait_idle();
    read_word(16'h0007, 16'hffff);
    prog(16'h0005, 16'hf0f0);
    read_word(16'h0005, 16'hf0f0);
    prog(16'h0005, 16'h3c3c);
    read_word(16'h0005, 16'h3030);
    check({15'h0, STATUS.busy}, 16'h0);
  endtask
  // deselect and foreign commands while programming
  task automatic t_busy_filter;
    u_host.send(fpec_pkg::CMD_WORD_PROG, 16'h0010, 16'h0000);
    CHIP_SEL = 1'b0;
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0000, 16'h0);
    u_host.send(fpec_pkg::CMD_STATUS, 16'h0, 16'h0);
    check({15'h0, READ_VALID}, 16'h1);
    check({15'h0, STATUS.prog_busy}, 16'h1);
    wait_idle();
    CHIP_SEL = 1'b1;
    read_word(16'h0005, 16'h3030);
    read_word(16'h0010, 16'h0000);
  endtask
  task automatic t_map_power;
    u_host.send(fpec_pkg::CMD_MAP_ENTER, 16'h0, 16'h0);
    check({15'h0, STATUS.map_window}, 16'h1);
    u_host.send(fpec_pkg::CMD_LOW_POWER, 16'h0, 16'h0);
    check({15'h0, STATUS.low_power}, 16'h0);
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0000, 16'h0);
    wait_idle();
    prog(16'h0005, 16'h00ff);
    read_word(16'h0005, 16'h00ff);
    u_host.send(fpec_pkg::CMD_MAP_EXIT, 16'h0, 16'h0);
    check({15'h0, STATUS.map_window}, 16'h0);
    read_word(16'h0005, 16'h3030);
    u_host.send(fpec_pkg::CMD_LOW_POWER, 16'h0, 16'h0);
    check({15'h0, STATUS.low_power}, 16'h1);
    u_host.send(fpec_pkg::CMD_WAKE, 16'h0, 16'h0);
    check({15'h0, STATUS.low_power}, 16'h0);
  endtask
  // erase of sector 1 suspended, program into sector 0 meanwhile
  task automatic t_suspend;
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0800, 16'h0);
    u_host.send(fpec_pkg::CMD_ERASE_SUSP, 16'h0800, 16'h0);
    check({14'h0, STATUS.erase_susp, BUSY}, 16'h2);
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0000, 16'h0);
    check({15'h0, BUSY}, 16'h0);
    prog(16'h0020, 16'hff00);
    check({15'h0, STATUS.erase_susp}, 16'h1);
    read_word(16'h0020, 16'hff00);
    // resume is left to run out: no suspend follows within the gap
    u_host.send(fpec_pkg::CMD_ERASE_RES, 16'h0800, 16'h0);
    wait_idle();
    check({15'h0, STATUS.erase_susp}, 16'h0);
    read_word(16'h0800, 16'hffff);
  endtask
  // program suspended, erase refused, other-line read served
  task automatic t_prog_suspend;
    u_host.send(fpec_pkg::CMD_WORD_PROG, 16'h0040, 16'h1234);
    u_host.send(fpec_pkg::CMD_PROG_SUSP, 16'h0040, 16'h0);
    check({14'h0, STATUS.prog_susp, BUSY}, 16'h2);
    u_host.send(fpec_pkg::CMD_ERASE, 16'h0800, 16'h0);
    check({15'h0, STATUS.prog_susp}, 16'h1);
    read_word(16'h0800, 16'hffff);
    u_host.send(fpec_pkg::CMD_PROG_RES, 16'h0040, 16'h0);
    wait_idle();
    read_word(16'h0040, 16'h1234);
  endtask
  // reset in mid-program, then recovery
  task automatic t_abort;
    u_host.send(fpec_pkg::CMD_WORD_PROG, 16'h0030, 16'h0000);
    RESET = 1'b1;
    @(posedge CLK);
    #1;
    RESET = 1'b0;
    check({15'h0, BUSY}, 16'h0);
    u_host.send(fpec_pkg::CMD_READ, 16'h0005, 16'h0);
    check({15'h0, READ_VALID}, 16'h0);
    repeat (6) @(posedge CLK);
    read_word(16'h0005, 16'h3030);
    read_word(16'h0030, 16'hffff);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge CLK);
    #1;
    RESET = 1'b0;
    repeat (6) @(posedge CLK);
    t_program();
    t_busy_filter();
    t_map_power();
    t_suspend();
    t_prog_suspend();
    t_abort();
    finish_test();
  end
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
